/* verification/fpsc_flash_pe_suspend_tb.sv */
`timescale 1ns/1ps

module fpsc_flash_pe_suspend_tb;
  import fpsc_pkg::*;
  localparam int EC = 60;
  localparam int PC = 40;
  localparam int SD = 8;

  logic        mclk;
  logic        rst_n;
  logic        fault_pin;
  logic        sequencer_ready;
  logic        irq;
  logic [31:0] reg_rdata;
  logic [31:0] reg_wdata;
  logic [7:0]  reg_addr;
  logic [7:0]  cmd_data;
  logic        reg_wr;
  logic        reg_rd;
  logic        cmd_wr;
  logic        cmd_byte;
  logic        cmd_in_region;
  logic        quiet;
  logic        rd_d;
  logic [31:0] exp_q[$];
  logic [31:0] d;
  logic [7:0]  st;
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 44;
  int          n;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  fpsc_flash_pe_suspend #(.ERASE_CYC(32'(EC)), .PROG_CYC(32'(PC)), .SUSPEND_DLY(32'(SD))) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_wr(cmd_wr), .cmd_byte(cmd_byte),
    .cmd_in_region(cmd_in_region), .cmd_data(cmd_data), .fault_pin(fault_pin),
    .sequencer_ready(sequencer_ready), .irq(irq));

  fpsc_host_model #(.ERASE_CYC(EC), .SUSP_DLY(SD)) host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .cmd_wr(cmd_wr), .cmd_byte(cmd_byte),
    .cmd_in_region(cmd_in_region), .cmd_data(cmd_data), .quiet(quiet));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Checked read: the expectation is queued before the strobe goes out.
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    exp_q.push_back(e);
    host.rd(a, v);
  endtask

  task automatic poll_ready();
    int          k;
    logic [31:0] v;
    k = 0;
    v = '0;
    while (!v[FS_READY] && k < 50)
    begin
      host.prd(REG_FSTAT, v);
      k++;
    end
    chk(32'(v[FS_READY]), 32'h1);
  endtask

  task automatic pulse_fault();
    @(posedge mclk);
    fault_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    fault_pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Monitor: each checked read result is compared with the oldest queued note.
  always @(posedge mclk) rd_d <= reg_rd & ~quiet;
  always @(negedge mclk)
    if (rd_d && exp_q.size() > 0)
    begin
      chk(reg_rdata, exp_q.pop_front());
    end

  // Watchdog sized well above the expected run of a few hundred cycles.
  initial
  begin
    #(20000 * 50);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    rst_n = 1'b0;
    fault_pin = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(32'(sequencer_ready), 32'h1);
    chk(32'(irq), 32'h0);
    rdx(REG_FSTAT, 32'h1);
    rdx(REG_FAULT, 32'h0);
    rdx(REG_FRST, 32'h0);
    host.wr(8'h20, $random(seed));
    rdx(8'h20, 32'h0);
    rdx(REG_OPCTL, 32'h0);
    d = $random(seed);
    host.wr(REG_IMASK, d);
    rdx(REG_IMASK, {29'h0, d[2:0]});
    host.wr(REG_IMASK, 32'h0);
    $display("Test reset and register map done");
    // Program suspended through the host procedure, then the interrupt path.
    host.wr(REG_OPCTL, 32'h1);
    rdx(REG_FSTAT, 32'h2);
    chk(32'(sequencer_ready), 32'h0);
    host.suspend(st);
    chk(32'(st), 32'h9);
    chk(32'(sequencer_ready), 32'h1);
    rdx(REG_ISTAT, 32'h2);
    chk(32'(irq), 32'h0);
    host.wr(REG_IMASK, 32'h2);
    repeat (2) @(negedge mclk);
    chk(32'(irq), 32'h1);
    host.wr(REG_ISTAT, 32'h2);
    repeat (2) @(negedge mclk);
    chk(32'(irq), 32'h0);
    host.wr(REG_IMASK, 32'h0);
    $display("Test program suspend done");
    // Erase suspended after a random delay, accept flag checked at once.
    host.wr(REG_OPCTL, 32'h2);
    n = $random(seed) & 7;
    repeat (n) @(posedge mclk);
    host.cmd(CMD_SUSPEND, 1'b1, 1'b1);
    rdx(REG_FSTAT, 32'h4);
    poll_ready();
    rdx(REG_FSTAT, 32'h5);
    $display("Test erase suspend done");
    // Operation finishes before any suspend is requested.
    host.wr(REG_OPCTL, 32'h1);
    repeat (PC + 4) @(posedge mclk);
    rdx(REG_FSTAT, 32'h1);
    host.suspend(st);
    chk(32'(st), 32'h1);
    rdx(REG_ISTAT, 32'h3);
    host.wr(REG_ISTAT, 32'h7);
    $display("Test completion done");
    // Wrong suspend forms: word wide, outside the region, wrong code.
    for (int i = 0; i < 3; i++)
    begin
      host.wr(REG_OPCTL, 32'h2);
      host.cmd(i == 2 ? 8'h20 : CMD_SUSPEND, i != 0, i != 1);
      rdx(REG_FSTAT, 32'h11);
      rdx(REG_FAULT, 32'h10);
      host.clear_illegal();
      rdx(REG_FAULT, 32'h0);
      rdx(REG_FSTAT, 32'h1);
    end
    $display("Test illegal commands done");
    // Fault during erase, then a controller fault that only a reset clears.
    host.wr(REG_OPCTL, 32'h2);
    pulse_fault();
    host.suspend(st);
    chk(32'(st), 32'h21);
    host.cmd(CMD_STATUS_CLEAR, 1'b1, 1'b1);
    rdx(REG_FSTAT, 32'h1);
    pulse_fault();
    rdx(REG_FSTAT, 32'h81);
    host.cmd(CMD_STATUS_CLEAR, 1'b1, 1'b1);
    rdx(REG_FSTAT, 32'h81);
    host.reinit();
    rdx(REG_FSTAT, 32'h1);
    $display("Test faults and reinit done");
    end_of_test();
  end
endmodule // fpsc_flash_pe_suspend_tb

/* verification/fpsc_host_model.sv */
`timescale 1ns/1ps

// Host software model: register port master, command writer and the suspend procedure.
module fpsc_host_model #(
  parameter int ERASE_CYC = 20,
  parameter int SUSP_DLY  = 5,
  parameter int RST_HOLD  = 4
)
(
  input  wire logic                        mclk,
  input  wire logic [fpsc_pkg::DATA_W-1:0] reg_rdata,
  output logic      [fpsc_pkg::ADDR_W-1:0] reg_addr,
  output logic      [fpsc_pkg::DATA_W-1:0] reg_wdata,
  output logic                             reg_wr,
  output logic                             reg_rd,
  output logic                             cmd_wr,
  output logic                             cmd_byte,
  output logic                             cmd_in_region,
  output logic      [7:0]                  cmd_data,
  output logic                             quiet
);
  import fpsc_pkg::*;

  // Everything idles low at time zero.
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {cmd_wr, cmd_byte, cmd_in_region, cmd_data, quiet} = '0;
  end

  // Released data lines are inverted so a stale value never passes for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  // Polling reads are flagged so the bench monitor skips them.
  task automatic prd(input logic [7:0] a, output logic [31:0] d);
    quiet = 1'b1;
    rd(a, d);
    quiet = 1'b0;
  endtask

  task automatic cmd(input logic [7:0] c, input logic bw, input logic inr);
    @(posedge mclk);
    cmd_data      <= c;
    cmd_byte      <= bw;
    cmd_in_region <= inr;
    cmd_wr        <= 1'b1;
    @(posedge mclk);
    cmd_wr        <= 1'b0;
    cmd_data      <= ~c;
  endtask

  task automatic reinit();
    wr(REG_FRST, 32'h1);
    repeat (RST_HOLD) @(posedge mclk);
    wr(REG_FRST, 32'h0);
  endtask

  task automatic clear_illegal();
    logic [31:0] d;
    prd(REG_FAULT, d);
    if (d[7:0] == FAULT_ILLEGAL) wr(REG_FAULT, 32'(FAULT_ILLEGAL));
    cmd(CMD_STATUS_CLEAR, 1'b1, 1'b1);
  endtask

  // Returns the last status seen; the caller takes the error path on error bits.
  task automatic suspend(output logic [7:0] st);
    logic [31:0] d;
    int          n;
    prd(REG_FSTAT, d);
    st = d[7:0];
    if (|d[7:4]) return;
    n = 0;
    while (!d[FS_SUSP_ACC] && !d[FS_READY] && n < ERASE_CYC)
    begin
      prd(REG_FSTAT, d);
      n += 2;
    end
    st = d[7:0];
    if (d[FS_READY] || !d[FS_SUSP_ACC]) return;
    cmd(CMD_SUSPEND, 1'b1, 1'b1);
    // Two spare cycles allow for the latency of the last poll.
    n = 0;
    d = '0;
    while (!d[FS_READY] && n <= SUSP_DLY * 11 / 10 + 2)
    begin
      prd(REG_FSTAT, d);
      n += 2;
    end
    if (!d[FS_READY]) reinit();
    st = d[7:0];
  endtask
endmodule // fpsc_host_model

/* verilog/fpsc_flash_pe_suspend.sv */
// Functional notes
// RULE_01 - Suspend-accept flag clears as soon as a suspend command is accepted.
// RULE_02 - Suspend-accept flag clears on entering command-locked state during program or erase.
// RULE_03 - Suspend-accept flag clears when program or erase completes, suspend or not.
// RULE_04 - Host checks all four error flags are zero before suspending.
// RULE_05 - Host suspend-accept wait exits on sequencer ready, bounded by block erase time.
// RULE_06 - Suspend is a byte write of B0h inside the region being worked on.
// RULE_07 - Host polls ready for 1.1 suspend delays, else reinitialises controller.
// RULE_08 - Reinitialise by holding controller reset bit one for reset pulse width.
// RULE_09 - On illegal command, host clears fault status 10h then issues status clear.
// RULE_10 - After suspend, host reads erase-suspended and program-suspended flags.
// RULE_11 - Suspend-accept wait timeout equals the erase time of one 128-Kbyte block.
// RULE_12 - Suspend sets exactly one suspended flag, matching the operation, then ready.
`timescale 1ns/1ps

module fpsc_flash_pe_suspend #(
  parameter logic [31:0] ERASE_CYC   = fpsc_pkg::BLOCK_ERASE_CYC,
  parameter logic [31:0] PROG_CYC    = fpsc_pkg::PROGRAM_CYC,
  parameter logic [31:0] SUSPEND_DLY = fpsc_pkg::SUSPEND_CYC
)
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [fpsc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [fpsc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [fpsc_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                          cmd_wr,
  input  wire logic                          cmd_byte,
  input  wire logic                          cmd_in_region,
  input  wire logic [7:0]                    cmd_data,
  input  wire logic                          fault_pin,
  output logic                               sequencer_ready,
  output logic                               irq
);
  import fpsc_pkg::*;

  typedef struct packed {
    fpsc_state_t             st;
    logic                    ready;
    logic                    susp_acc;
    logic                    ers_spd;
    logic                    prg_spd;
    logic                    ilgl;
    logic                    ers_err;
    logic                    prg_err;
    logic                    ctl_err;
    logic [7:0]              fault;
    logic                    frst;
    logic                    fault_prev;
    logic [IRQ_W-1:0]        istat;
    logic [IRQ_W-1:0]        imask;
    logic                    irq;
    logic [DATA_W-1:0]       rdata;
  } fpsc_top_t;

  // Idle and ready, no flags, nothing masked in.
  localparam fpsc_top_t Q_RST = '{st: ST_IDLE, ready: 1'b1, fault: FAULT_NONE, default: '0};

  fpsc_top_t         q;
  fpsc_top_t         d;
  logic              fault_lvl;
  logic              t_exp;
  logic              t_load;
  logic [31:0]       t_val;
  logic              t_abort;
  logic              busy;
  logic              sus_take;
  logic              lock_now;
  logic              ev_done;
  logic              ev_susp;
  logic              ev_err;
  logic [IRQ_W-1:0]  w1c;

  // The fault pin comes from outside the clock domain.
  fpsc_sync3 u_fault_sync
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (fault_pin),
    .level (fault_lvl)
  );

  // One timer serves program, erase and suspend delay since they never overlap.
  fpsc_timer #(
    .W (32)
  ) u_timer
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .load    (t_load),
    .count   (t_val),
    .abort   (t_abort),
    .expired (t_exp)
  );

  // Sequencer, flags, register port and interrupt logic.
  always_comb
  begin
    d        = q;
    t_load   = 1'b0;
    t_val    = '0;
    t_abort  = 1'b0;
    ev_done  = 1'b0;
    ev_susp  = 1'b0;
    ev_err   = 1'b0;
    sus_take = 1'b0;
    lock_now = 1'b0;
    w1c      = '0;
    busy     = (q.st == ST_PROG) || (q.st == ST_ERASE);
    d.fault_prev = fault_lvl;
    d.rdata  = '0;

    // Register writes: the reset bit and mask store a value, fault and interrupt status writes clear.
    if (reg_wr)
    begin
      if (reg_addr == REG_FRST)
      begin
        d.frst = reg_wdata[FRST_BIT];
      end
      else if (reg_addr == REG_FAULT)
      begin
        if ((reg_wdata[7:0] == FAULT_ILLEGAL) && (q.fault == FAULT_ILLEGAL))
        begin
          d.fault = FAULT_NONE; // see RULE_09
        end
      end
      else if (reg_addr == REG_IMASK)
      begin
        d.imask = reg_wdata[IRQ_W-1:0];
      end
      else if (reg_addr == REG_ISTAT)
      begin
        w1c = reg_wdata[IRQ_W-1:0];
      end
    end

    if (q.frst)
    begin
      // Holding the reset bit parks the controller; the whole operation is abandoned.
      d.st       = ST_IDLE; // see RULE_08
      d.ready    = 1'b1;
      d.susp_acc = 1'b0;
      d.ers_spd  = 1'b0;
      d.prg_spd  = 1'b0;
      d.ilgl     = 1'b0;
      d.ers_err  = 1'b0;
      d.prg_err  = 1'b0;
      d.ctl_err  = 1'b0;
      d.fault    = FAULT_NONE;
      t_abort    = 1'b1;
    end
    else
    begin
      case (q.st)
        ST_IDLE, ST_SUSPENDED:
        begin
          if (cmd_wr && (cmd_data == CMD_STATUS_CLEAR))
          begin
            d.ilgl    = 1'b0;
            d.ers_err = 1'b0;
            d.prg_err = 1'b0;
          end
          else if (cmd_wr && (cmd_data == CMD_SUSPEND))
          begin
            lock_now = 1'b1; // Nothing is running, so a suspend here is illegal.
          end
          else if (reg_wr && (reg_addr == REG_OPCTL) &&
                   (reg_wdata[OP_PROG_BIT] || reg_wdata[OP_ERASE_BIT]))
          begin
            d.st       = reg_wdata[OP_PROG_BIT] ? ST_PROG : ST_ERASE;
            d.ready    = 1'b0;
            d.susp_acc = 1'b1;
            d.ers_spd  = 1'b0;
            d.prg_spd  = 1'b0;
            t_load     = 1'b1;
            t_val      = reg_wdata[OP_PROG_BIT] ? PROG_CYC : ERASE_CYC; // see RULE_11
          end
        end
        ST_PROG, ST_ERASE:
        begin
          if (t_exp)
          begin
            d.st       = ST_IDLE;
            d.ready    = 1'b1;  // see RULE_05
            d.susp_acc = 1'b0;  // see RULE_03
            ev_done    = 1'b1;
          end
          else if (cmd_wr && cmd_byte && cmd_in_region && (cmd_data == CMD_SUSPEND) && q.susp_acc)
          begin
            sus_take   = 1'b1;  // see RULE_06
            d.st       = ST_SUSP_WAIT;
            d.susp_acc = 1'b0;  // see RULE_01
            d.ers_spd  = 1'b0;
            d.prg_spd  = 1'b0;
            d.prg_err  = q.prg_err;
            t_load     = 1'b1;
            t_val      = SUSPEND_DLY;
            d.frst     = q.frst;
            d.ilgl     = q.ilgl;
            d.ers_err  = (q.st == ST_ERASE) ? q.ers_err : q.ers_err;
            d.ready    = 1'b0;
            d.fault    = q.fault;
            d.prg_spd  = 1'b0;
            d.ers_spd  = (q.st == ST_ERASE); // Remembers which kind was interrupted.
          end
          else if (cmd_wr)
          begin
            lock_now = 1'b1;
          end
        end
        ST_SUSP_WAIT:
        begin
          if (t_exp)
          begin
            // The erase flag was raised at acceptance; the program flag joins ready here, so exactly one stands.
            d.st      = ST_SUSPENDED;
            d.prg_spd = !q.ers_spd; // see RULE_12
            d.ready   = 1'b1;       // see RULE_12
            ev_susp   = 1'b1;
          end
        end
        ST_LOCKED:
        begin
          // Only the status-clear command leaves the locked state; an internal error needs a reset.
          if (cmd_wr && (cmd_data == CMD_STATUS_CLEAR) && !q.ctl_err)
          begin
            d.st      = ST_IDLE;
            d.ilgl    = 1'b0;
            d.ers_err = 1'b0;
            d.prg_err = 1'b0;
          end
        end
        default:
        begin
          d.st = ST_IDLE;
        end
      endcase

      // A fault pin edge marks the error of the running operation, or the controller error when no program or erase runs, and locks the controller.
      if (fault_lvl && !q.fault_prev)
      begin
        if (q.st == ST_PROG)
        begin
          d.prg_err = 1'b1;
        end
        else if (q.st == ST_ERASE)
        begin
          d.ers_err = 1'b1;
        end
        else
        begin
          d.ctl_err = 1'b1;
        end
        d.st       = ST_LOCKED;
        d.ready    = 1'b1;
        d.susp_acc = 1'b0; // see RULE_02
        d.ers_spd  = 1'b0;
        d.prg_spd  = 1'b0;
        t_abort    = 1'b1;
        ev_err     = 1'b1;
      end
      else if (lock_now)
      begin
        d.st       = ST_LOCKED;
        d.ready    = 1'b1;
        d.ilgl     = 1'b1;
        d.fault    = FAULT_ILLEGAL;
        d.susp_acc = 1'b0; // see RULE_02
        t_abort    = 1'b1;
        ev_err     = 1'b1;
      end
    end

    // Interrupt status: a new event wins over a write-one clear in the same cycle.
    d.istat = (q.istat & ~w1c) | {ev_err, ev_susp, ev_done};
    d.irq   = |(d.istat & d.imask);

    // Read data stand for exactly one cycle; unmapped offsets read zero.
    if (reg_rd)
    begin
      if (reg_addr == REG_FSTAT)
      begin
        d.rdata[FS_READY]    = q.ready;
        d.rdata[FS_SUSP_ACC] = q.susp_acc;
        d.rdata[FS_ERS_SPD]  = q.ers_spd; // see RULE_10
        d.rdata[FS_PRG_SPD]  = q.prg_spd; // see RULE_10
        d.rdata[FS_ILGL]     = q.ilgl;    // see RULE_04
        d.rdata[FS_ERS_ERR]  = q.ers_err;
        d.rdata[FS_PRG_ERR]  = q.prg_err;
        d.rdata[FS_CTL_ERR]  = q.ctl_err; // see RULE_07
      end
      else if (reg_addr == REG_FAULT)
      begin
        d.rdata[7:0] = q.fault;
      end
      else if (reg_addr == REG_FRST)
      begin
        d.rdata[FRST_BIT] = q.frst;
      end
      else if (reg_addr == REG_ISTAT)
      begin
        d.rdata[IRQ_W-1:0] = q.istat;
      end
      else if (reg_addr == REG_IMASK)
      begin
        d.rdata[IRQ_W-1:0] = q.imask;
      end
    end
  end

  // All state of the block.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= Q_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata       = q.rdata;
  assign sequencer_ready = q.ready;
  assign irq             = q.irq;

  // Checks.
  localparam int SUSP_WAIT_MAX = 402;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    sus_take && !q.frst;
  endsequence

  sequence s_suspend_done;
    (q.st == ST_SUSPENDED) && q.ready;
  endsequence

  AST_ACC_CLR_ON_SUSPEND: assert property (s_take |=> !q.susp_acc && (q.st == ST_SUSP_WAIT)) // see RULE_01
    else $error("Suspend-accept flag not cleared after suspend acceptance.");

  AST_ACC_CLR_ON_LOCK: assert property (busy && lock_now && !q.frst |=> !q.susp_acc && (q.st == ST_LOCKED)) // see RULE_02
    else $error("Suspend-accept flag not cleared on lock during operation.");

  AST_ACC_CLR_ON_DONE: assert property (busy && t_exp && !q.frst |=> !q.susp_acc && q.ready) // see RULE_03
    else $error("Suspend-accept flag not cleared on completion.");

  AST_ACC_ONLY_BUSY: assert property (q.susp_acc |-> busy && !q.ready) // see RULE_03
    else $error("Suspend-accept flag set outside a running operation.");

  AST_SUSP_SEQUENCE: assert property (s_take ##1 (!q.frst && !fault_lvl) |-> // see RULE_12
                                      (!q.ready throughout (q.st == ST_SUSP_WAIT)[*1])
                                      ##[1:SUSP_WAIT_MAX] s_suspend_done)
    else $error("Suspend did not finish with ready in time.");

  AST_SUSP_ONE_FLAG: assert property ((q.st == ST_SUSPENDED) |-> (q.ers_spd ^ q.prg_spd)) // see RULE_12
    else $error("Suspended state without exactly one suspended flag.");

  AST_SUSP_KIND: assert property ((s_take and (q.st == ST_ERASE)) ##1 !q.frst |-> q.ers_spd && !q.prg_spd) // see RULE_12
    else $error("Suspended flag does not match the interrupted operation.");

  AST_ILLEGAL_FAULT: assert property (lock_now && !(fault_lvl && !q.fault_prev) |=> // see RULE_09
                                      q.ilgl && (q.fault == FAULT_ILLEGAL) && q.ready)
    else $error("Illegal command did not set fault status.");

  AST_RDATA_ONE_CYCLE: assert property (!reg_rd |=> (reg_rdata == '0))
    else $error("Read data present without a read.");

  AST_IRQ_LEVEL: assert property ($rose(irq) |-> |(q.istat & q.imask))
    else $error("Interrupt raised with no unmasked status bit.");

endmodule // fpsc_flash_pe_suspend

/* verilog/fpsc_pkg.sv */
package fpsc_pkg;

  // Register port geometry.
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0]  REG_FSTAT = 8'h00;
  localparam logic [7:0]  REG_FAULT = 8'h04;
  localparam logic [7:0]  REG_FRST  = 8'h08;
  localparam logic [7:0]  REG_OPCTL = 8'h0c;
  localparam logic [7:0]  REG_ISTAT = 8'h10;
  localparam logic [7:0]  REG_IMASK = 8'h14;

  // Bit positions of flash_status_0.
  localparam int          FS_READY     = 0;
  localparam int          FS_SUSP_ACC  = 1;
  localparam int          FS_ERS_SPD   = 2;
  localparam int          FS_PRG_SPD   = 3;
  localparam int          FS_ILGL      = 4;
  localparam int          FS_ERS_ERR   = 5;
  localparam int          FS_PRG_ERR   = 6;
  localparam int          FS_CTL_ERR   = 7;

  // Control bits.
  localparam int          FRST_BIT     = 0;
  localparam int          OP_PROG_BIT  = 0;
  localparam int          OP_ERASE_BIT = 1;

  // Interrupt status layout.
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_SUSP     = 1;
  localparam int          IRQ_ERR      = 2;

  // Command codes and fault values.
  localparam logic [7:0]  CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0]  CMD_STATUS_CLEAR = 8'h50;
  localparam logic [7:0]  FAULT_ILLEGAL    = 8'h10;
  localparam logic [7:0]  FAULT_NONE       = 8'h00;

  // Timing, in nanoseconds, and the derived cycle counts at 20 MHz.
  localparam longint      CLK_PERIOD_NS         = 50;
  localparam longint      BLOCK_ERASE_TIME_NS   = 1000000;
  localparam longint      PROGRAM_TIME_NS       = 100000;
  localparam longint      SUSPEND_DELAY_TIME_NS = 20000;
  localparam logic [31:0] BLOCK_ERASE_CYC = 32'(BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [31:0] PROGRAM_CYC     = 32'(PROGRAM_TIME_NS / CLK_PERIOD_NS);
  localparam logic [31:0] SUSPEND_CYC     = 32'(SUSPEND_DELAY_TIME_NS / CLK_PERIOD_NS);

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_PROG      = 3'b001,
    ST_ERASE     = 3'b010,
    ST_SUSP_WAIT = 3'b011,
    ST_SUSPENDED = 3'b100,
    ST_LOCKED    = 3'b101
  } fpsc_state_t;

endpackage

/* verilog/fpsc_sync3.sv */
`timescale 1ns/1ps

module fpsc_sync3
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } fpsc_sync_t;

  fpsc_sync_t q;
  fpsc_sync_t d;

  // The first stage feeds only the second; the output moves once stages two and three agree.
  always_comb
  begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3)
    begin
      d.level = q.s3;
    end
  end

  // Synchroniser flops.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level = q.level;

endmodule // fpsc_sync3

/* verilog/fpsc_timer.sv */
`timescale 1ns/1ps

module fpsc_timer #(
  parameter int W = 32
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  input  wire logic         abort,
  output logic              expired
);

  typedef struct packed {
    logic         run;
    logic [W-1:0] cnt;
    logic         expired;
  } fpsc_tmr_t;

  fpsc_tmr_t q;
  fpsc_tmr_t d;

  // Counts down from the loaded value; expired pulses count cycles after the load.
  always_comb
  begin
    d = q;
    d.expired = 1'b0;
    if (abort)
    begin
      d.run = 1'b0;
    end
    else if (load)
    begin
      d.run = 1'b1;
      d.cnt = count;
    end
    else if (q.run)
    begin
      if (q.cnt <= W'(1))
      begin
        d.run = 1'b0;
        d.expired = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt - W'(1);
      end
    end
  end

  // Timer flops.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign expired = q.expired;

endmodule // fpsc_timer
